// ===== hw/pia_top.sv
// prioritized interrupt arbiter with apb register access
// Functional notes
// [R01] one prioritization round per instruction cycle among all requesters
// [R02] winner served only if its level strictly exceeds cpu priority
// [R03] acceptance needs source enable and global gate
// [R04] eight-bit control register per source, identical layout, all bits rw
// [R05] word access reads upper byte zero, ignores writes there
// [R06] hardware sets pending flag on a source request
// [R07] pending cleared on cpu entry or on channel service
// [R08] pending stays set when channel count reaches zero
// [R09] software set or clear of pending acts like hardware
// [R10] per-source enable allows or blocks acceptance
// [R11] level field at bits 5..2, Fh highest
// [R12] levels 15 and 14 go to channel unless its count is zero
// [R13] levels 13 to 1 always plain cpu interrupts
// [R14] channel number is level lsb then group bits
// [R15] group priority breaks same-level ties, 3 highest
// [R16] highest channel number wins among channel requests
// [R17] entry pushes old status word then loads winner level
// [R18] level zero sources never served
// [R19] nesting up to fifteen routines at distinct levels
// [R20] up to four sources share a level by group value
// [R21] software keeps groups distinct on one level
// [R22] gate clear: no acceptance, no channel transfers
// [R23] cpu priority field at 15..12, reset to zero
// [R24] cpu at 15 blocks channels; at 14 only channels 4..7
// [R25] winner identity and service type shown after each round
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module pia_top
    import pia_pkg::*;
(
    input  wire logic                         clk_sys,
    input  wire logic                         arst_n,
    input  wire logic                         round_tick,
    input  wire logic [pia_pkg::NUM_SRC-1:0]  src_req,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output var  logic [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    output var  logic                         win_valid,
    output var  logic [pia_pkg::SRC_W-1:0]    win_src,
    output var  logic [1:0]                   win_type,
    output var  logic [2:0]                   win_chan,
    output var  logic [15:0]                  psw_pushed,
    output var  logic                         psw_push,
    output var  logic [15:0]                  psw_out
);
    import pia_pkg::*;

    // ------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------
    logic       rst_n;
    logic [NUM_SRC-1:0] req_s;

    pia_sync #(.W(1)) u_rst (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .din     (1'b1),
        .dout    (rst_n)
    );

    pia_sync #(.W(NUM_SRC)) u_req (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .din     (src_req),
        .dout    (req_s)
    );

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [7:0]          src_ctl [NUM_SRC];
    logic [7:0]          chan_cnt [NUM_CHAN];
    logic [15:0]         processor_status_word;
    logic [3:0]          nest_depth;
    logic                wr_acc;
    logic                rd_acc;
    logic                sel_src;
    logic                sel_chan;
    logic [SRC_W-1:0]    sel_idx;
    logic                mapped;
    logic                rd_wait;
    logic                sel_status;
    logic                sel_service;

    // single-word register match
    function automatic logic word_hit(input logic [11:0] a, input logic [11:0] base);
        word_hit = (a == base);
    endfunction : word_hit

    // window match for the eight-entry register banks
    function automatic logic bank_hit(input logic [11:0] a, input logic [11:0] base);
        bank_hit = (a[11:5] == base[11:5]);
    endfunction : bank_hit

    // one read wait state: prdata stays a flop yet stands at the ready edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_wait <= 1'b0;
        end else begin
            rd_wait <= psel && penable && !pwrite && !rd_wait;
        end
    end

    assign pready      = pwrite || rd_wait;
    assign wr_acc      = psel && penable && pwrite && mapped;
    assign rd_acc      = psel && penable && !pwrite && !rd_wait;
    assign sel_src     = bank_hit(paddr, ADDR_SRC_BASE);
    assign sel_chan    = bank_hit(paddr, ADDR_CHAN_BASE);
    assign sel_status  = word_hit(paddr, ADDR_STATUS);
    assign sel_service = word_hit(paddr, ADDR_SERVICE);
    assign sel_idx     = paddr[4:2];
    // refused accesses have no effect on any register
    assign mapped      = (paddr[1:0] == 2'h0) &&
                         (sel_src || sel_chan || sel_status || sel_service ||
                          word_hit(paddr, ADDR_RESULT));
    assign pslverr     = psel && penable && !mapped;

    // ------------------------------------------------------------
    // round of prioritization
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0]   cand;
    logic [NUM_SRC*6-1:0] keys;
    logic                 found;
    logic [SRC_W-1:0]     w_idx;
    logic [5:0]           w_key;
    logic [3:0]           w_lvl;
    logic [2:0]           w_chan;
    logic                 chan_route;
    logic                 chan_allow;
    logic                 grant;
    logic                 chan_svc;
    logic                 cpu_svc;
    logic                 ack_entry;
    logic [3:0]           win_lvl;

    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_cand
            // candidates need pending, own enable and gate [R03] [R10] [R22]
            assign cand[g] = src_ctl[g][CTL_REQ_BIT] && src_ctl[g][CTL_EN_BIT] &&
                             processor_status_word[PSW_GATE_BIT];
            assign keys[g*6 +: 6] = pia_key(src_ctl[g]); // [R15] [R16] [R20]
        end
    endgenerate

    pia_pick u_pick (
        .cand  (cand),
        .keys  (keys),
        .found (found),
        .idx   (w_idx),
        .key   (w_key)
    );

    assign w_lvl  = w_key[5:2]; // [R11]
    assign w_chan = {w_lvl[0], w_key[1:0]}; // [R14]
    // only 111x levels can route to a channel [R12] [R13]
    assign chan_route = (w_lvl[3:1] == LVL_CHAN_HI[3:1]) && (chan_cnt[w_chan] != COUNT_RESET);
    // strict compare also blocks level 0 and channels under cpu 15/14 [R02] [R18] [R24]
    assign chan_allow = (w_lvl > processor_status_word[PSW_LVL_HI:PSW_LVL_LO]);
    // an entry ack holds the round off, so no channel grant goes unreported
    assign grant     = round_tick && !ack_entry && found && chan_allow &&
                       (w_lvl != LVL_NONE); // [R01]
    assign chan_svc  = grant && chan_route;
    assign cpu_svc   = grant && !chan_route;
    assign ack_entry = wr_acc && sel_service && pwdata[SVC_ACK_BIT] && win_valid &&
                       (win_type == 2'(PIA_SVC_CPU));

    // ------------------------------------------------------------
    // source control registers
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_ctl
            logic hit;
            logic clr_hw;
            assign hit    = wr_acc && sel_src && (sel_idx == SRC_W'(g)) && pstrb[0];
            // clear on entry, or on channel service unless count ends at 0 [R07] [R08]
            assign clr_hw = (ack_entry && win_src == SRC_W'(g)) ||
                            (chan_svc && w_idx == SRC_W'(g) &&
                             chan_cnt[w_chan] != 8'h01);
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    src_ctl[g] <= CTL_RESET;
                end else begin
                    if (hit) begin
                        src_ctl[g] <= pwdata[7:0]; // [R04] [R05] [R09]
                    end else if (clr_hw) begin
                        src_ctl[g][CTL_REQ_BIT] <= 1'b0;
                    end
                    if (req_s[g]) begin
                        src_ctl[g][CTL_REQ_BIT] <= 1'b1; // set wins [R06]
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // channel counters
    // ------------------------------------------------------------
    generate
        for (genvar c = 0; c < NUM_CHAN; c++) begin : g_cnt
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    chan_cnt[c] <= COUNT_RESET;
                end else if (wr_acc && sel_chan && sel_idx == 3'(c) && pstrb[0]) begin
                    chan_cnt[c] <= pwdata[7:0];
                end else if (chan_svc && w_chan == 3'(c) &&
                             chan_cnt[c] != COUNT_ENDLESS) begin
                    chan_cnt[c] <= chan_cnt[c] - 8'h01;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // status word and nesting
    // ------------------------------------------------------------
    logic sw_write;

    assign sw_write = wr_acc && sel_status;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            processor_status_word <= PSW_RESET; // [R23]
        end else if (ack_entry) begin
            processor_status_word[PSW_LVL_HI:PSW_LVL_LO] <= win_lvl; // [R17]
        end else if (sw_write) begin
            // software restores level on return
            if (pstrb[1]) begin
                processor_status_word[15:8] <= pwdata[15:8];
            end
            if (pstrb[0]) begin
                processor_status_word[7:0] <= pwdata[7:0];
            end
        end
    end

    // old word out on the same edge that the new level lands [R17]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            psw_pushed <= PSW_RESET;
            psw_push   <= 1'b0;
        end else begin
            psw_push <= ack_entry;
            if (ack_entry) begin
                psw_pushed <= processor_status_word;
            end
        end
    end

    // depth saturates so a runaway nest cannot wrap [R19]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nest_depth <= 4'h0;
        end else if (ack_entry) begin
            if (nest_depth != STACK_DEPTH[3:0]) begin
                nest_depth <= nest_depth + 4'h1;
            end
        end else if (sw_write && pstrb[1] && pwdata[15:12] < processor_status_word[15:12] &&
                     nest_depth != 4'h0) begin
            nest_depth <= nest_depth - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // round result
    // ------------------------------------------------------------
    // identity moves only at a round, an entry ack keeps it [R25]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            win_src  <= '0;
            win_chan <= 3'h0;
            win_lvl  <= LVL_NONE;
        end else if (round_tick && !ack_entry) begin
            win_src  <= w_idx;
            win_chan <= w_chan;
            win_lvl  <= w_lvl;
        end
    end

    // grant state, dropped by the entry ack
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            win_valid <= 1'b0;
            win_type  <= 2'(PIA_SVC_NONE);
        end else if (ack_entry) begin
            win_valid <= 1'b0;
            win_type  <= 2'(PIA_SVC_NONE);
        end else if (round_tick) begin
            // result shown after every round [R25]
            win_valid <= grant;
            win_type  <= chan_svc ? 2'(PIA_SVC_CHAN) :
                         cpu_svc  ? 2'(PIA_SVC_CPU) : 2'(PIA_SVC_NONE);
        end
    end

    assign psw_out = processor_status_word;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0] next_rdata;

    // refused accesses read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (!mapped) begin
            next_rdata = 32'h0000_0000;
        end else if (sel_src) begin
            next_rdata = {24'h00_0000, src_ctl[sel_idx]}; // [R04] [R05]
        end else if (sel_chan) begin
            next_rdata = {24'h00_0000, chan_cnt[sel_idx]};
        end else if (sel_status) begin
            next_rdata = {16'h0000, processor_status_word};
        end else if (word_hit(paddr, ADDR_RESULT)) begin
            next_rdata = {14'h0000, nest_depth, win_lvl, 1'b0, win_chan,
                          win_valid, win_type, win_src};
        end
    end

    // loaded in the first access cycle, so it stands at the ready edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            prdata <= next_rdata;
        end
    end
endmodule : pia_top
`default_nettype wire

// ===== hw/pia_pkg.sv
// package of constants and types for the prioritized interrupt arbiter
package pia_pkg;
    localparam int          NUM_SRC         = 8;
    localparam int          SRC_W           = 3;
    localparam int          NUM_CHAN        = 8;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_SRC_BASE   = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h040;
    localparam logic [11:0] ADDR_CHAN_BASE  = 12'h080;
    localparam logic [11:0] ADDR_RESULT     = 12'h0C0;
    localparam logic [11:0] ADDR_SERVICE    = 12'h0C4;
    // ------------------------------------------------------------
    // source control field positions
    // ------------------------------------------------------------
    localparam int          CTL_REQ_BIT     = 7;
    localparam int          CTL_EN_BIT      = 6;
    localparam int          CTL_LVL_HI      = 5;
    localparam int          CTL_LVL_LO      = 2;
    localparam int          CTL_GRP_HI      = 1;
    localparam int          CTL_GRP_LO      = 0;
    // ------------------------------------------------------------
    // status word field positions
    // ------------------------------------------------------------
    localparam int          PSW_LVL_HI      = 15;
    localparam int          PSW_LVL_LO      = 12;
    localparam int          PSW_GATE_BIT    = 11;
    // ------------------------------------------------------------
    // service word layout and reset values
    // ------------------------------------------------------------
    localparam int          SVC_ACK_BIT     = 0;
    localparam logic [7:0]  CTL_RESET       = 8'h00;
    localparam logic [15:0] PSW_RESET       = 16'h0000;
    localparam logic [7:0]  COUNT_RESET     = 8'h00;
    localparam logic [7:0]  COUNT_ENDLESS   = 8'hFF;
    localparam logic [3:0]  LVL_CHAN_HI     = 4'hF;
    localparam logic [3:0]  LVL_CHAN_LO     = 4'hE;
    localparam logic [3:0]  LVL_NONE        = 4'h0;
    localparam logic [15:0] STACK_DEPTH     = 16'h000F;

    typedef enum logic [1:0] {
        PIA_SVC_NONE,
        PIA_SVC_CPU,
        PIA_SVC_CHAN
    } pia_svc_t;

    // level and group joined into one ranking key
    function automatic logic [5:0] pia_key(input logic [7:0] ctl);
        pia_key = {ctl[CTL_LVL_HI:CTL_LVL_LO], ctl[CTL_GRP_HI:CTL_GRP_LO]};
    endfunction : pia_key
endpackage : pia_pkg

// ===== hw/pia_sync.sv
// two-flop synchroniser for request lines and reset release
`timescale 1ns/100ps
`default_nettype none
module pia_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule : pia_sync
`default_nettype wire

// ===== hw/pia_pick.sv
// combinational winner search over ranking keys
`timescale 1ns/100ps
`default_nettype none
module pia_pick
    import pia_pkg::*;
(
    input  wire logic [pia_pkg::NUM_SRC-1:0] cand,
    input  wire logic [pia_pkg::NUM_SRC*6-1:0] keys,
    output var  logic                        found,
    output var  logic [pia_pkg::SRC_W-1:0]   idx,
    output var  logic [5:0]                  key
);
    import pia_pkg::*;

    // lowest index wins exact ties; software must keep keys distinct
    always_comb begin
        found = 1'b0;
        idx   = '0;
        key   = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (cand[i] && (!found || keys[i*6 +: 6] > key)) begin
                found = 1'b1;
                idx   = SRC_W'(i);
                key   = keys[i*6 +: 6];
            end
        end
    end
endmodule : pia_pick
`default_nettype wire

// ===== verif/pia_sva.sv
// port assertions for the interrupt arbiter
`timescale 1ns/100ps
`default_nettype none
module pia_sva
    import pia_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        round_tick,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        win_valid,
    input wire logic [2:0]  win_src,
    input wire logic [1:0]  win_type,
    input wire logic [2:0]  win_chan,
    input wire logic [15:0] psw_pushed,
    input wire logic        psw_push,
    input wire logic [15:0] psw_out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // ----
    // sequences and checks
    // ----
    sequence s_quiet;
        psw_out == PSW_RESET && !win_valid && !psw_push;
    endsequence
    sequence s_entry;
        psw_push ##1 !psw_push;
    endsequence
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access waited more than one cycle");
    chk_round_only: assert property (!$past(round_tick) |-> $stable(win_src) && $stable(win_chan))
        else $error("winner moved outside a round");
    chk_gate_block: assert property (round_tick && !psw_out[PSW_GATE_BIT] |=> !win_valid)
        else $error("grant with gate closed");
    chk_level_cap: assert property (round_tick && psw_out[15:12] == 4'hF |=> !win_valid)
        else $error("grant at top cpu level");
    chk_push_pulse: assert property ($rose(psw_push) |-> s_entry)
        else $error("push not one cycle");
    chk_push_level: assert property (psw_push |-> ##[0:1] psw_out[15:12] > psw_pushed[15:12])
        else $error("entry level not above old");
    chk_push_gate: assert property (psw_push |-> psw_pushed[PSW_GATE_BIT])
        else $error("entry with gate closed");
    chk_valid_type: assert property (win_valid |-> win_type != PIA_SVC_NONE)
        else $error("grant without type");
    chk_unmapped_err: assert property (psel && penable && paddr[11:8] != 4'h0 |-> pslverr)
        else $error("unmapped access accepted");
    chk_reset_quiet: assert property ($rose(arst_n) |-> s_quiet [*2])
        else $error("outputs not quiet after reset");
endmodule : pia_sva
bind pia_top pia_sva chk (.clk_sys, .arst_n, .round_tick, .psel, .penable, .paddr, .pready,
    .pslverr, .win_valid, .win_src, .win_type, .win_chan, .psw_pushed, .psw_push, .psw_out);
`default_nettype wire

// ===== verif/pia_src_model.sv
// peripheral request source model
`timescale 1ns/100ps
`default_nettype none
module pia_src_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] fire,
    output var  logic [7:0] src_req
);
    // ----
    // request stretcher
    // ----
    logic [1:0] hold = 2'h0;
    logic [7:0] mask = 8'h00;
    // three cycles so the two-flop input stage always catches it
    always @(posedge clk_sys) begin
        if (fire != 8'h00) begin
            mask <= fire;
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end
    // a quiet source drives its line low
    assign src_req = (hold != 2'h0) ? mask : 8'h00;
endmodule : pia_src_model
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the interrupt arbiter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pia_pkg::*;
    // ----
    // signals
    // ----
    logic        clk_sys = 1'b0, arst_n = 1'b0, round_tick = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, win_take = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic [3:0]  pstrb = 4'h0;
    logic [7:0]  fire = 8'h00, src_req;
    logic        pready, pslverr, win_valid, psw_push;
    logic [2:0]  win_src, win_chan;
    logic [1:0]  win_type;
    logic [15:0] psw_pushed, psw_out;
    logic [8:0]  we, wg, win_q[$];
    logic [32:0] rd_q[$], ent_q[$];
    logic [7:0]  setup[8] = '{8'hC3, 8'h00, 8'hD5, 8'hB0, 8'h00, 8'hD7, 8'h00, 8'h00};
    int          err_count = 0, total_checks = 0;
    always #4 clk_sys = ~clk_sys;
    pia_top dut (.clk_sys, .arst_n, .round_tick, .src_req, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .win_valid, .win_src, .win_type,
        .win_chan, .psw_pushed, .psw_push, .psw_out);
    pia_src_model peers (.clk_sys, .fire, .src_req);
    // ----
    // tasks
    // ----
    function automatic logic [11:0] sa(int i);
        return ADDR_SRC_BASE + 12'(4 * i);
    endfunction : sa
    function automatic logic [11:0] ca(int i);
        return ADDR_CHAN_BASE + 12'(4 * i);
    endfunction : ca
    task automatic cmp(string what, logic [32:0] exp, logic [32:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(logic [11:0] a, logic [32:0] exp);
        rd_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic enter(logic [31:0] exp);
        ent_q.push_back({1'b0, exp});
        wr(ADDR_SERVICE, 32'h1);
    endtask : enter
    task automatic tick(logic [8:0] exp);
        win_q.push_back(exp);
        @(posedge clk_sys);
        round_tick <= 1'b1;
        @(posedge clk_sys);
        round_tick <= 1'b0;
        win_take <= 1'b1;
    endtask : tick
    // read data and error are taken at the edge that sees ready high
    always @(posedge clk_sys) begin
        if (psel && penable && !pwrite && pready) begin
            cmp("read", rd_q.pop_front(), {pslverr, prdata});
        end
        if (psw_push) begin
            cmp("entry", ent_q.pop_front(), {1'b0, psw_out, psw_pushed});
        end
        if (win_take) begin
            win_take <= 1'b0;
            we = win_q.pop_front();
            wg = {win_valid, win_type, win_src, win_chan};
            if (!we[8])
                wg[5:0] = we[5:0];
            cmp("round", {24'h0, we}, {24'h0, wg});
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        summarize();
    end
    // ----
    // scenarios
    // ----
    initial begin
        v = $urandom(32'hB58A);
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(ADDR_STATUS, {17'h0, PSW_RESET});
        for (int i = 0; i < NUM_SRC; i++) begin
            v = $urandom();
            rd(sa(i), {25'h0, CTL_RESET});
            wr(sa(i), v);
            rd(sa(i), {25'h0, v[7:0]});
            wr(sa(i), {24'h0, setup[i]});
        end
        rd(12'h100, 33'h1_0000_0000);
        fire <= 8'h02;
        @(posedge clk_sys);
        fire <= 8'h00;
        repeat (6) @(posedge clk_sys);
        rd(sa(1), 33'h80);
        wr(ADDR_STATUS, 32'h0800);
        tick({1'b1, PIA_SVC_CPU, 3'h5, 3'h7});
        enter(32'h5800_0800);
        rd(ADDR_STATUS, 33'h5800);
        rd(sa(5), 33'h57);
        tick({1'b0, PIA_SVC_NONE, 6'h0});
        wr(ADDR_STATUS, 32'h0000);
        tick({1'b0, PIA_SVC_NONE, 6'h0});
        wr(ADDR_STATUS, 32'h0800);
        tick({1'b1, PIA_SVC_CPU, 3'h2, 3'h5});
        enter(32'h5800_0800);
        wr(ADDR_STATUS, 32'h0800);
        wr(ca(7), 32'h2);
        wr(sa(4), 32'hFB);
        wr(sa(6), 32'hFF);
        tick({1'b1, PIA_SVC_CHAN, 3'h6, 3'h7});
        rd(ca(7), 33'h1);
        rd(sa(6), 33'h7F);
        wr(sa(6), 32'hFF);
        tick({1'b1, PIA_SVC_CHAN, 3'h6, 3'h7});
        rd(ca(7), 33'h0);
        rd(sa(6), 33'hFF);
        tick({1'b1, PIA_SVC_CPU, 3'h6, 3'h7});
        enter(32'hF800_0800);
        rd(ADDR_STATUS, 33'hF800);
        tick({1'b0, PIA_SVC_NONE, 6'h0});
        wr(sa(4), 32'h0);
        wr(ca(5), 32'h3);
        wr(sa(7), 32'hF5);
        wr(ADDR_STATUS, 32'h0800);
        tick({1'b1, PIA_SVC_CPU, 3'h7, 3'h5});
        repeat (2) @(posedge clk_sys);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
